// ---- sea_pkg.sv ----
// package of constants and types for the serial eeprom access logic
package sea_pkg;

  // ********************************************************************
  // geometry
  // ********************************************************************
  localparam int unsigned ARRAY_BYTES = 16384;
  localparam int unsigned PAGE_BYTES  = 64;
  localparam int unsigned ARR_AW      = 14;
  localparam int unsigned PAGE_AW     = 6;
  localparam int unsigned FIFO_DEPTH  = 32;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;

  // ********************************************************************
  // opcodes
  // ********************************************************************
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_SR_READ   = 8'h05;
  localparam logic [7:0] OP_SR_WRITE  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // ********************************************************************
  // status bit positions
  // ********************************************************************
  localparam int unsigned SB_RDY  = 0;
  localparam int unsigned SB_WR_LATCH = 1;
  localparam int unsigned SB_PROT_LO  = 2;
  localparam int unsigned SB_PROT_HI  = 3;
  localparam int unsigned SB_PG_LOCK  = 4;
  localparam int unsigned SB_PG_SEL   = 6;
  localparam int unsigned SB_PIN_EN   = 7;
  localparam logic [7:0]  SR_WR_MASK   = 8'hdc;
  localparam logic [7:0]  SR_OLD_BUSY  = 8'hff;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned T_WRITE_US   = 5;
  localparam int unsigned WRITE_CYCLES = T_WRITE_US * CLK_MHZ;
  localparam int unsigned WCNT_W       = 13;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [5:0] {
    ST_OPCODE = 6'h01,
    ST_ADDR   = 6'h02,
    ST_WDATA  = 6'h04,
    ST_RDATA  = 6'h08,
    ST_SDATA  = 6'h10,
    ST_IGNORE = 6'h20
  } sea_frame_e;

  typedef struct packed {
    logic [13:0] addr;
    logic [7:0]  data;
  } sea_wword_s;

endpackage : sea_pkg

// ---- sea_fifo.sv ----
// parameterised valid/ready fifo that buffers page write bytes
`timescale 1ns/100ps
module sea_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out,
  // flush
  input  wire logic             flush_in
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = mem[rd_ptr_ff];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || flush_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_in)
    disable iff (srst_in) count_ff <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule // sea_fifo

// ---- sea_eeprom.sv ----
// command and access logic of a serial eeprom with identification page
//
// Operation
// - page write loads up to 32 bytes (fifo depth), low address wraps in page
// - write enable latch clears when internal write finishes
// - id page uses address bits 5..0 only
// - id page write refused in protected area, never with both bits set
// - id page write refused while the lock bit is one
// - status write changes only bits 2,3,4,6,7
// - protect pin low with pin enable blocks status writes
// - protect pin falling in frame aborts status write, not after
// - pin enable zero makes protect pin ignored
// - read opcode, 16-bit address, data follows last address bit
// - sequential read advances and wraps; chip select high ends read
// - id page read uses six-bit pointer and increments it
// - status read always answered; older revision gives ff when busy
// - hold tri-states output and ignores input
// - start in standby with write enable latch clear
// - chip select high launches write; array ignored while busy
// - unknown opcode ignored, output high impedance for the frame
// - memory starts erased to ff
// - main array uses 14 low address bits
// - ready bit one during internal write, zero after
// - id page select clears after each read or write that ends while not busy
// - setting select and lock together leaves both unchanged
`timescale 1ns/100ps
module sea_eeprom #(
  parameter int unsigned WRITE_CYCLES = sea_pkg::WRITE_CYCLES,
  parameter bit          NEW_REV      = 1'b1
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // serial link pins
  input  wire logic sck_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  input  wire logic hold_n_in,
  input  wire logic wp_n_in,
  output logic      so_out,
  output logic      so_oe_out,
  // status view
  output logic      busy_out
);
  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic       sck_d_ff;
  logic       cs_d_ff;
  logic       wp_d_ff;
  logic       sck_s;
  logic       cs_s;
  logic       si_s;
  logic       hold_s;
  logic       wp_s;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_ff <= 5'h1e;
      sync_ff <= 5'h1e;
    end else begin
      meta_ff <= {wp_n_in, hold_n_in, si_in, cs_n_in, sck_in};
      sync_ff <= meta_ff;
    end
  end
  assign {wp_s, hold_s, si_s, cs_s, sck_s} = sync_ff;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sck_d_ff <= 1'b0;
      cs_d_ff  <= 1'b1;
      wp_d_ff  <= 1'b1;
    end else begin
      sck_d_ff <= sck_s;
      cs_d_ff  <= cs_s;
      wp_d_ff  <= wp_s;
    end
  end

  logic active;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  // hold freezes shifting and the output
  assign active  = !cs_s && hold_s;
  assign rise    = active && sck_s && !sck_d_ff;
  assign fall    = active && !sck_s && sck_d_ff;
  assign cs_fall = !cs_s && cs_d_ff;
  assign cs_rise = cs_s && !cs_d_ff;

  // ********************************************************************
  // storage and status
  // ********************************************************************
  logic [7:0] array_mem [sea_pkg::ARRAY_BYTES];
  logic [7:0] page_mem  [sea_pkg::PAGE_BYTES];
  logic [7:0] status_ff;
  logic       busy_ff;
  logic [sea_pkg::WCNT_W-1:0] wcnt_ff;

  initial begin
    for (int i = 0; i < sea_pkg::ARRAY_BYTES; i++) begin
      array_mem[i] = sea_pkg::ERASED_BYTE;
    end
    for (int i = 0; i < sea_pkg::PAGE_BYTES; i++) begin
      page_mem[i] = sea_pkg::ERASED_BYTE;
    end
  end

  // ********************************************************************
  // frame shifter
  // ********************************************************************
  sea_pkg::sea_frame_e state_ff;
  logic [7:0]  shin_ff;
  logic [2:0]  bit_ff;
  logic [3:0]  abit_ff;
  logic [15:0] addr_ff;
  logic [7:0]  opc_ff;
  logic [7:0]  shout_ff;
  logic        out_en_ff;
  logic [6:0]  nbytes_ff;
  logic        wp_abort_ff;
  logic        sr_pend_ff;
  logic [7:0]  sr_data_ff;
  logic [7:0]  nxt_byte;
  logic        byte_done;

  assign nxt_byte  = {shin_ff[6:0], si_s};
  assign byte_done = rise && (bit_ff == 3'h7);

  logic pg_sel;
  logic [7:0] rd_byte;
  logic [15:0] rd_next;
  assign pg_sel = status_ff[sea_pkg::SB_PG_SEL];
  // page pointer only in id mode, 14 bits in array mode
  assign rd_next = pg_sel
    ? {addr_ff[15:6], addr_ff[5:0] + 6'h01}
    : {2'h0, addr_ff[13:0] + 14'h0001};
  assign rd_byte = pg_sel ? page_mem[addr_ff[5:0]]
                       : array_mem[addr_ff[13:0]];

  logic [7:0] sr_view;
  // older revision hides the register while busy
  assign sr_view = (busy_ff && !NEW_REV) ? sea_pkg::SR_OLD_BUSY
                                         : status_ff;

  // fifo feed from the shifter
  sea_pkg::sea_wword_s fin;
  sea_pkg::sea_wword_s fout;
  logic fin_valid;
  logic fin_ready;
  logic fout_valid;
  logic fout_ready;
  logic fflush;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff    <= sea_pkg::ST_OPCODE;
      shin_ff     <= 8'h00;
      bit_ff      <= 3'h0;
      abit_ff     <= 4'h0;
      addr_ff     <= 16'h0000;
      opc_ff      <= 8'h00;
      nbytes_ff   <= 7'h00;
      wp_abort_ff <= 1'b0;
      sr_pend_ff  <= 1'b0;
      sr_data_ff  <= 8'h00;
    end else if (cs_s || cs_fall) begin
      state_ff    <= sea_pkg::ST_OPCODE;
      bit_ff      <= 3'h0;
      abit_ff     <= 4'h0;
      nbytes_ff   <= 7'h00;
      wp_abort_ff <= 1'b0;
      sr_pend_ff  <= 1'b0;
      // a stale opcode must not act again on an empty frame
      opc_ff      <= 8'h00;
    end else begin
      // falling protect pin inside the frame cancels a status write
      if (!wp_s && wp_d_ff && status_ff[sea_pkg::SB_PIN_EN]) begin
        wp_abort_ff <= 1'b1;
      end
      if (rise) begin
        shin_ff <= nxt_byte;
        bit_ff  <= bit_ff + 3'h1;
      end
      case (state_ff)
        sea_pkg::ST_OPCODE: begin
          if (byte_done) begin
            opc_ff <= nxt_byte;
            if (nxt_byte == sea_pkg::OP_READ ||
                nxt_byte == sea_pkg::OP_WRITE) begin
              state_ff <= sea_pkg::ST_ADDR;
            end else if (nxt_byte == sea_pkg::OP_SR_WRITE) begin
              state_ff <= sea_pkg::ST_WDATA;
            end else if (nxt_byte == sea_pkg::OP_SR_READ) begin
              state_ff <= sea_pkg::ST_SDATA;
            end else begin
              state_ff <= sea_pkg::ST_IGNORE;
            end
          end
        end
        sea_pkg::ST_ADDR: begin
          if (rise) begin
            addr_ff <= {addr_ff[14:0], si_s};
            abit_ff <= abit_ff + 4'h1;
            if (abit_ff == 4'hf) begin
              state_ff <= (opc_ff == sea_pkg::OP_READ)
                          ? sea_pkg::ST_RDATA : sea_pkg::ST_WDATA;
            end
          end
        end
        sea_pkg::ST_WDATA: begin
          if (byte_done) begin
            if (opc_ff == sea_pkg::OP_SR_WRITE) begin
              sr_data_ff <= nxt_byte;
              sr_pend_ff <= 1'b1;
            end else begin
              // only the in-page bits advance
              addr_ff[5:0] <= addr_ff[5:0] + 6'h01;
              if (nbytes_ff != 7'(sea_pkg::PAGE_BYTES)) begin
                nbytes_ff <= nbytes_ff + 7'h01;
              end
            end
          end
        end
        sea_pkg::ST_RDATA: begin
          if (byte_done) begin
            addr_ff <= rd_next;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ********************************************************************
  // serial output, changes on falling sck
  // ********************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in || cs_s) begin
      shout_ff  <= 8'h00;
      out_en_ff <= 1'b0;
    end else if (state_ff == sea_pkg::ST_IGNORE) begin
      out_en_ff <= 1'b0;
    end else if (fall && (bit_ff == 3'h0)) begin
      if (state_ff == sea_pkg::ST_RDATA) begin
        shout_ff  <= rd_byte;
        out_en_ff <= !busy_ff;
      end else if (state_ff == sea_pkg::ST_SDATA) begin
        shout_ff  <= sr_view;
        out_en_ff <= 1'b1;
      end
    end else if (fall) begin
      shout_ff <= {shout_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
      busy_out  <= 1'b0;
    end else begin
      so_out    <= shout_ff[7];
      so_oe_out <= out_en_ff && active;
      busy_out  <= busy_ff;
    end
  end

  // ********************************************************************
  // commit at frame end and internal write cycle
  // ********************************************************************
  logic wr_latch;
  logic [1:0] bp;
  logic arr_prot;
  logic pg_ok;
  logic sr_ok;
  logic data_write;
  logic commit;
  assign wr_latch = status_ff[sea_pkg::SB_WR_LATCH];
  assign bp = {status_ff[sea_pkg::SB_PROT_HI], status_ff[sea_pkg::SB_PROT_LO]};
  // array byte address bits 13..12 checked against the protect ranges; id page uses bit 5 in pg_ok
  assign arr_prot = (bp == 2'h3) ||
                    (bp == 2'h2 && addr_ff[13]) ||
                    (bp == 2'h1 && addr_ff[13:12] == 2'h3);
  assign pg_ok = !(bp == 2'h3) && !status_ff[sea_pkg::SB_PG_LOCK]
                 && !((bp != 2'h0) && addr_ff[5]);
  assign sr_ok = !(status_ff[sea_pkg::SB_PIN_EN] && !wp_s)
                 && !wp_abort_ff;
  assign data_write = (opc_ff == sea_pkg::OP_WRITE) && (nbytes_ff != 7'h00)
                      && (bit_ff == 3'h0)
                      && (pg_sel ? pg_ok : !arr_prot);
  assign commit = cs_rise && !busy_ff && wr_latch &&
                  ((sr_pend_ff && sr_ok) || data_write);

  // drain only once the frame has closed, so the fifo really fills
  assign fin.addr   = {addr_ff[13:6], addr_ff[5:0]};
  assign fin.data   = nxt_byte;
  assign fin_valid  = byte_done && (state_ff == sea_pkg::ST_WDATA) &&
                      (opc_ff == sea_pkg::OP_WRITE) && !busy_ff;
  assign fout_ready = busy_ff;
  assign fflush     = cs_fall;

  logic pg_wr_ff;
  always_ff @(posedge clk_in) begin
    if (fout_valid && fout_ready) begin
      if (pg_wr_ff) begin
        page_mem[fout.addr[5:0]] <= fout.data;
      end else begin
        array_mem[fout.addr] <= fout.data;
      end
    end
  end

  logic [7:0] sr_new;
  always_comb begin
    sr_new = (status_ff & ~sea_pkg::SR_WR_MASK) |
             (sr_data_ff & sea_pkg::SR_WR_MASK);
    if (sr_data_ff[sea_pkg::SB_PG_SEL] && sr_data_ff[sea_pkg::SB_PG_LOCK]) begin
      sr_new[sea_pkg::SB_PG_SEL]  = status_ff[sea_pkg::SB_PG_SEL];
      sr_new[sea_pkg::SB_PG_LOCK] = status_ff[sea_pkg::SB_PG_LOCK];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      status_ff <= 8'h00;
      busy_ff   <= 1'b0;
      wcnt_ff   <= '0;
      pg_wr_ff  <= 1'b0;
    end else if (busy_ff) begin
      if (wcnt_ff == '0) begin
        busy_ff                  <= 1'b0;
        status_ff[sea_pkg::SB_RDY] <= 1'b0;
        status_ff[sea_pkg::SB_WR_LATCH] <= 1'b0;
      end else begin
        wcnt_ff <= wcnt_ff - 1'b1;
      end
    end else if (commit) begin
      busy_ff                  <= 1'b1;
      wcnt_ff <= sea_pkg::WCNT_W'(WRITE_CYCLES - 1);
      status_ff[sea_pkg::SB_RDY] <= 1'b1;
      pg_wr_ff <= pg_sel && !sr_pend_ff;
      if (sr_pend_ff) begin
        status_ff[7:2] <= sr_new[7:2];
      end else begin
        status_ff[sea_pkg::SB_PG_SEL] <= 1'b0;
      end
    end else if (cs_rise && !busy_ff) begin
      if (opc_ff == sea_pkg::OP_WR_ENABLE && bit_ff == 3'h0) begin
        status_ff[sea_pkg::SB_WR_LATCH] <= 1'b1;
      end else if (opc_ff == sea_pkg::OP_WRDI && bit_ff == 3'h0) begin
        status_ff[sea_pkg::SB_WR_LATCH] <= 1'b0;
      end else if (opc_ff == sea_pkg::OP_READ ||
                   opc_ff == sea_pkg::OP_WRITE) begin
        status_ff[sea_pkg::SB_PG_SEL] <= 1'b0;
      end
    end
  end

  sea_fifo #(
    .WIDTH ($bits(sea_pkg::sea_wword_s)),
    .DEPTH (sea_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (fin_valid),
    .in_ready_out  (fin_ready),
    .in_data_in    (fin),
    .out_valid_out (fout_valid),
    .out_ready_in  (fout_ready),
    .out_data_out  (fout),
    .flush_in      (fflush)
  );

  // ********************************************************************
  // checks
  // ********************************************************************
  a_busy_rdy_tied: assert property (@(posedge clk_in) disable iff (srst_in)
    busy_ff |-> status_ff[sea_pkg::SB_RDY])
    else $error("ready bit low while busy");
  a_latch_clears_end: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(busy_ff) |-> !status_ff[sea_pkg::SB_WR_LATCH])
    else $error("write enable latch survived write cycle");
  a_hold_tristate: assert property (@(posedge clk_in) disable iff (srst_in)
    !hold_s |=> !so_oe_out)
    else $error("output driven during hold");
  a_ignore_quiet: assert property (@(posedge clk_in) disable iff (srst_in)
    state_ff == sea_pkg::ST_IGNORE |=> ##1 !so_oe_out)
    else $error("output driven after unknown opcode");
  a_sr_fixed_bits: assert property (@(posedge clk_in) disable iff (srst_in)
    (commit && sr_pend_ff) |=> status_ff[5] == $past(status_ff[5]))
    else $error("status bit 5 changed by status write");
  a_sr_pin_block: assert property (@(posedge clk_in) disable iff (srst_in)
    (status_ff[sea_pkg::SB_PIN_EN] && !wp_s && sr_pend_ff) |-> !commit)
    else $error("status write passed protect pin");
  a_pg_lock_refuse: assert property (@(posedge clk_in) disable iff (srst_in)
    (pg_sel && status_ff[sea_pkg::SB_PG_LOCK]) |-> !data_write)
    else $error("locked id page accepted write");
  a_pg_full_prot: assert property (@(posedge clk_in) disable iff (srst_in)
    (pg_sel && bp == 2'h3) |-> !data_write)
    else $error("id page write under full protection");
  a_pg_sel_autoclr: assert property (@(posedge clk_in) disable iff (srst_in)
    (commit && !sr_pend_ff) |=> !status_ff[sea_pkg::SB_PG_SEL])
    else $error("id page select not cleared");
endmodule // sea_eeprom

// ---- sea_host.sv ----
// host side serial bus model driving the eeprom pins
`timescale 1ns/100ps
module sea_host (
  // clock
  input  wire logic clk_in,
  // serial link pins
  input  wire logic so_in,
  input  wire logic so_oe_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      hold_n_out,
  output logic      wp_n_out
);
  logic so_last_ff;
  logic seen_oe = 1'b0;
  logic hold_oe = 1'b0;
  initial begin
    sck_out    = 1'b0;
    cs_n_out   = 1'b1;
    si_out     = 1'b0;
    hold_n_out = 1'b1;
    wp_n_out   = 1'b1;
  end
  // released output line reads back inverted
  always_ff @(posedge clk_in) begin
    if (so_oe_in) so_last_ff <= so_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic sel();
    tick(2);
    cs_n_out = 1'b0;
    seen_oe  = 1'b0;
    tick(3);
  endtask
  task automatic desel();
    tick(3);
    cs_n_out = 1'b1;
    si_out   = ~si_out;
    tick(8);
  endtask
  // one byte each way, msb first, sampled on rising sck
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_out = tx[i];
      tick(5);
      sck_out = 1'b1;
      rx[i]   = so_oe_in ? so_in : ~so_last_ff;
      seen_oe = seen_oe | so_oe_in;
      tick(5);
      sck_out = 1'b0;
    end
  endtask
  // pause with sck low, si wiggled meanwhile
  task automatic pause();
    tick(2);
    hold_n_out = 1'b0;
    tick(3);
    si_out = ~si_out;
    tick(5);
    hold_oe    = so_oe_in;
    hold_n_out = 1'b1;
    tick(2);
  endtask
endmodule // sea_host

// ---- tb.sv ----
// self-checking bench for the serial eeprom access logic
`timescale 1ns/100ps
module tb;
  // ****************
  // pins and state
  // ****************
  logic       clk_in  = 1'b0;
  logic       srst_in = 1'b1;
  logic       sck, cs_n, si, hold_n, wp_n, so, so_oe, busy;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic       do_hold = 1'b0;
  logic       drop_wp = 1'b0;
  int         n_errors = 0;
  int         num_checks = 0;
  always #4 clk_in = ~clk_in;
  sea_eeprom #(.WRITE_CYCLES(1500), .NEW_REV(1'b1)) u_dut (
    .clk_in(clk_in), .srst_in(srst_in), .sck_in(sck),
    .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n),
    .wp_n_in(wp_n), .so_out(so), .so_oe_out(so_oe),
    .busy_out(busy));
  sea_host u_host (
    .clk_in(clk_in), .so_in(so), .so_oe_in(so_oe),
    .sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .hold_n_out(hold_n), .wp_n_out(wp_n));
  // ****************
  // access tasks
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk4(input logic [31:0] e);
    for (int i = 0; i < 4; i++) chk(rq[i], e[31-8*i -: 8]);
  endtask
  task automatic xfer(input logic [7:0] op, input logic [15:0] a,
                      input int nd);
    logic [7:0] r;
    rq = {};
    u_host.sel();
    u_host.xbyte(op, r);
    if (op == sea_pkg::OP_READ || op == sea_pkg::OP_WRITE) begin
      u_host.xbyte(a[15:8], r);
      u_host.xbyte(a[7:0], r);
    end
    for (int i = 0; i < nd; i++) begin
      if (i == 1 && do_hold) begin
        u_host.pause();
        chk({7'h00, u_host.hold_oe}, 8'h00);
      end
      u_host.xbyte(i < wq.size() ? wq[i] : 8'h00, r);
      rq.push_back(r);
    end
    // pin dips and recovers before chip select rises: only the abort blocks
    if (drop_wp && op == sea_pkg::OP_SR_WRITE) begin
      u_host.wp_n_out = 1'b0;
      u_host.tick(4);
      u_host.wp_n_out = 1'b1;
    end
    u_host.desel();
  endtask
  task automatic write_enable_cmd();
    xfer(sea_pkg::OP_WR_ENABLE, 16'h0000, 0);
  endtask
  task automatic status_read_cmd();
    xfer(sea_pkg::OP_SR_READ, 16'h0000, 1);
  endtask
  task automatic rd4(input logic [15:0] a);
    xfer(sea_pkg::OP_READ, a, 4);
  endtask
  task automatic wr1(input logic [15:0] a, input logic [7:0] d);
    wq = {d};
    write_enable_cmd();
    xfer(sea_pkg::OP_WRITE, a, 1);
    wait_rdy();
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 60; k++) begin
      status_read_cmd();
      if (rq[0][0] === 1'b0) return;
    end
    chk(8'h01, 8'h00);
  endtask
  task automatic status_write_cmd_go(input logic [7:0] v);
    write_enable_cmd();
    wq = {v};
    xfer(sea_pkg::OP_SR_WRITE, 16'h0000, 1);
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    status_write_cmd_go(v);
    wait_rdy();
  endtask
  task automatic st_chk(input logic [7:0] e);
    status_read_cmd();
    chk(rq[0] & 8'hfd, e);
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (12) @(posedge clk_in);
    #1 srst_in = 1'b0;
    u_host.tick(4);
    chk({6'h00, so_oe, busy}, 8'h00);
    status_read_cmd();
    chk(rq[0], 8'h00);
    rd4(16'h2a51);
    chk4(32'hffffffff);
    $display("test reset done");
    wq = {8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
    write_enable_cmd();
    xfer(sea_pkg::OP_WRITE, 16'h003c, 8);
    chk({7'h00, busy}, 8'h01);
    rd4(16'h0000);
    chk({7'h00, u_host.seen_oe}, 8'h00);
    status_read_cmd();
    chk(rq[0], 8'h03);
    wait_rdy();
    status_read_cmd();
    chk(rq[0], 8'h00);
    rd4(16'hfffe);
    chk4(32'hffff1415);
    do_hold = 1'b1;
    rd4(16'h403c);
    do_hold = 1'b0;
    chk4(32'h10111213);
    $display("test page done");
    status_write_cmd(8'hff);
    st_chk(8'h8c);
    u_host.wp_n_out = 1'b0;
    status_write_cmd(8'h00);
    st_chk(8'h8c);
    u_host.wp_n_out = 1'b1;
    drop_wp = 1'b1;
    status_write_cmd(8'h00);
    drop_wp = 1'b0;
    st_chk(8'h8c);
    u_host.wp_n_out = 1'b1;
    status_write_cmd_go(8'h00);
    u_host.wp_n_out = 1'b0;
    wait_rdy();
    st_chk(8'h00);
    status_write_cmd(8'h0c);
    st_chk(8'h0c);
    u_host.wp_n_out = 1'b1;
    xfer(8'hab, 16'h0000, 3);
    chk({7'h00, u_host.seen_oe}, 8'h00);
    $display("test status done");
    status_write_cmd(8'h40);
    wr1(16'hffc5, 8'ha5);
    st_chk(8'h00);
    status_write_cmd(8'h40);
    rd4(16'h0005);
    chk4(32'ha5ffffff);
    rd4(16'h0005);
    chk4(32'hffffffff);
    status_write_cmd(8'h48);
    wr1(16'h0025, 8'h5a);
    status_write_cmd(8'h40);
    rd4(16'h0025);
    chk4(32'hffffffff);
    $display("test id page done");
    summarize();
  end
  initial begin
    #800000;
    n_errors++;
    summarize();
  end
endmodule // tb
